// ===== cso_pkg.sv
`default_nettype none
package cso_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          NUM_REGS   = 5;
  localparam int          IDX_W      = 3;
  localparam logic [7:0]  REG_FIRST  = 8'h04;
  localparam logic [7:0]  REG_LAST   = 8'h08;
  localparam logic [2:0]  IDX_POLICY = 3'h0;  // clock_select_policy, 0x04
  localparam logic [2:0]  IDX_DRIVE  = 3'h1;  // cmos_drive_strength, 0x05
  localparam logic [2:0]  IDX_FORMAT = 3'h2;  // output_format_sleep, 0x06
  localparam logic [2:0]  IDX_FOSREF = 3'h3;  // freq_offset_reference, 0x07
  localparam logic [2:0]  IDX_HOLD   = 3'h4;  // output_static_hold, 0x08

  // Reset values and writable-bit masks, indexed by register index
  localparam logic [7:0] RST_VAL [NUM_REGS] = '{8'h12, 8'hed, 8'h2d, 8'h2a, 8'h00};
  localparam logic [7:0] WR_MASK [NUM_REGS] = '{8'hdf, 8'hc0, 8'h7f, 8'h07, 8'hf0};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POLICY_MSB = 7;
  localparam int POLICY_LSB = 6;
  localparam int HIST_MSB   = 4;
  localparam int HIST_LSB   = 0;
  localparam int DRIVE_MSB  = 7;
  localparam int DRIVE_LSB  = 6;
  localparam int SLEEP_BIT  = 6;
  localparam int FMT2_MSB   = 5;
  localparam int FMT2_LSB   = 3;
  localparam int FMT1_MSB   = 2;
  localparam int FMT1_LSB   = 0;
  localparam int FOS_MSB    = 2;
  localparam int FOS_LSB    = 0;
  localparam int HOLD2_MSB  = 7;
  localparam int HOLD2_LSB  = 6;
  localparam int HOLD1_MSB  = 5;
  localparam int HOLD1_LSB  = 4;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] POLICY_MANUAL = 2'h0;
  localparam logic [1:0] POLICY_NONREV = 2'h1;
  localparam logic [1:0] POLICY_REVERT = 2'h2;
  localparam logic [1:0] CHOICE_ONE    = 2'h0;
  localparam logic [1:0] CHOICE_TWO    = 2'h1;
  localparam logic [1:0] PRIO_TWO      = 2'h1;
  localparam logic [2:0] FMT_RSVD_A    = 3'h0;
  localparam logic [2:0] FMT_DISABLE   = 3'h1;
  localparam logic [2:0] FMT_CMOS      = 3'h2;
  localparam logic [2:0] FMT_RSVD_B    = 3'h4;
  localparam logic [2:0] FOS_XTAL      = 3'h0;
  localparam logic [2:0] FOS_IN_ONE    = 3'h1;
  localparam logic [2:0] FOS_IN_TWO    = 3'h2;
  localparam logic [2:0] FOS_SEL_XTAL  = 3'h1;
  localparam logic [2:0] FOS_SEL_ONE   = 3'h2;
  localparam logic [2:0] FOS_SEL_TWO   = 3'h4;
  localparam logic [2:0] FOS_SEL_NONE  = 3'h0;
  localparam logic [1:0] HOLD_LOW      = 2'h1;
  localparam logic [1:0] HOLD_HIGH     = 2'h2;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_ONE  = 2'b00,
    SEL_TWO  = 2'b01,
    SEL_HOLD = 2'b10
  } cso_sel_state_type;

  typedef enum logic [1:0] {
    G_PASS = 2'b00,
    G_LOW  = 2'b01,
    G_HIGH = 2'b10
  } cso_gate_state_type;

endpackage
`default_nettype wire

// ===== cso_gate_if.sv
`default_nettype none
// ------------------------------------------------------------------
// Output gate carrier: wanted level, raw clock phase, gated result
// ------------------------------------------------------------------
interface cso_gate_if;
  cso_pkg::cso_gate_state_type target;
  logic                        raw;
  logic                        out;

  modport ctrl (output target, output raw, input  out);
  modport gate (input  target, input  raw, output out);
endinterface
`default_nettype wire

// ===== cso_out_gate.sv
`default_nettype none
module cso_out_gate (
  input  wire logic  i_ref_clk,
  input  wire logic  i_srst,
  cso_gate_if.gate   bus
);

  // ----------------------------------------------------------------
  // Hold state machine
  // ----------------------------------------------------------------
  cso_pkg::cso_gate_state_type st_q;
  cso_pkg::cso_gate_state_type st_d;
  logic                        out_q;

  // A forced level is entered and left only while the raw phase already
  // sits at that level, so the output never shows a runt pulse
  always_comb begin
    st_d = st_q;
    case (st_q)
      cso_pkg::G_PASS: begin
        if (bus.target == cso_pkg::G_LOW && !bus.raw) begin
          st_d = cso_pkg::G_LOW;
        end else if (bus.target == cso_pkg::G_HIGH && bus.raw) begin
          st_d = cso_pkg::G_HIGH;
        end
      end
      cso_pkg::G_LOW: begin
        if (bus.target != cso_pkg::G_LOW && !bus.raw) begin
          st_d = cso_pkg::G_PASS;
        end
      end
      cso_pkg::G_HIGH: begin
        if (bus.target != cso_pkg::G_HIGH && bus.raw) begin
          st_d = cso_pkg::G_PASS;
        end
      end
      default: begin
        st_d = cso_pkg::G_LOW;
      end
    endcase
  end

  // State and registered output; starts parked low
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      st_q  <= cso_pkg::G_LOW;
      out_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      out_q <= (st_d == cso_pkg::G_PASS) ? bus.raw : (st_d == cso_pkg::G_HIGH);
    end
  end

  assign bus.out = out_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_no_runt;
    @(posedge i_ref_clk) disable iff (i_srst)
    (out_q != $past(out_q)) |-> ($past(bus.raw) == out_q);
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("gated output edge without raw edge");

  property p_held_low;
    @(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cso_pkg::G_LOW && bus.target == cso_pkg::G_LOW) |=> !out_q;
  endproperty
  a_held_low: assert property (p_held_low) else $error("held output not low");

  property p_held_high;
    @(posedge i_ref_clk) disable iff (i_srst)
    (st_q == cso_pkg::G_HIGH && bus.target == cso_pkg::G_HIGH) |=> out_q;
  endproperty
  a_held_high: assert property (p_held_high) else $error("held output not high");

endmodule
`default_nettype wire

// ===== cso_top.sv
`default_nettype none
module cso_top (
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rd_valid,
  input  wire logic        i_clock_select_pin,
  input  wire logic        i_select_source_pin_flag,
  input  wire logic [1:0]  i_register_input_choice,
  input  wire logic [1:0]  i_first_priority_input,
  input  wire logic        i_forced_holdover,
  input  wire logic        i_input_one_ok,
  input  wire logic        i_input_two_ok,
  input  wire logic [1:0]  i_out_raw_clk,
  output logic             o_active_input_two,
  output logic             o_holdover_active,
  output logic      [4:0]  o_history_delay,
  output logic      [1:0]  o_cmos_drive,
  output logic             o_power_down,
  output logic      [2:0]  o_out_one_format,
  output logic      [2:0]  o_out_two_format,
  output logic      [1:0]  o_out_buffer_enable,
  output logic      [1:0]  o_out_cmos_mode,
  output logic      [2:0]  o_offset_ref_select,
  output logic             o_clock_output_one,
  output logic             o_clock_output_two
);

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0]                  regs_q [cso_pkg::NUM_REGS];
  logic [7:0]                  addr_off;
  logic [cso_pkg::IDX_W-1:0]   reg_idx;
  logic                        reg_hit;

  assign addr_off = i_reg_addr - cso_pkg::REG_FIRST;
  assign reg_idx  = addr_off[cso_pkg::IDX_W-1:0];
  assign reg_hit  = (i_reg_addr >= cso_pkg::REG_FIRST) && (i_reg_addr <= cso_pkg::REG_LAST);

  // Reserved bits are forced back to their reset pattern on every write,
  // so software can never disturb them
  for (genvar r = 0; r < cso_pkg::NUM_REGS; r++) begin : g_reg
    always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
        regs_q[r] <= cso_pkg::RST_VAL[r];
      end else if (i_reg_wr && reg_hit && reg_idx == (cso_pkg::IDX_W)'(r)) begin
        regs_q[r] <= (i_reg_wdata & cso_pkg::WR_MASK[r])
                   | (cso_pkg::RST_VAL[r] & ~cso_pkg::WR_MASK[r]);
      end
    end
  end

  // Read port: answer one cycle after the strobe, unmapped reads give zero
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_reg_rdata    <= 8'h00;
      o_reg_rd_valid <= 1'b0;
    end else begin
      o_reg_rd_valid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= reg_hit ? regs_q[reg_idx] : 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  logic [1:0] policy;
  logic       sleep;
  logic [2:0] fmt   [2];
  logic [1:0] hold  [2];
  logic [2:0] fos_ref;

  assign policy  = regs_q[cso_pkg::IDX_POLICY][cso_pkg::POLICY_MSB:cso_pkg::POLICY_LSB];
  assign sleep   = regs_q[cso_pkg::IDX_FORMAT][cso_pkg::SLEEP_BIT];
  assign fmt[0]  = regs_q[cso_pkg::IDX_FORMAT][cso_pkg::FMT1_MSB:cso_pkg::FMT1_LSB];
  assign fmt[1]  = regs_q[cso_pkg::IDX_FORMAT][cso_pkg::FMT2_MSB:cso_pkg::FMT2_LSB];
  assign hold[0] = regs_q[cso_pkg::IDX_HOLD][cso_pkg::HOLD1_MSB:cso_pkg::HOLD1_LSB];
  assign hold[1] = regs_q[cso_pkg::IDX_HOLD][cso_pkg::HOLD2_MSB:cso_pkg::HOLD2_LSB];
  assign fos_ref = regs_q[cso_pkg::IDX_FOSREF][cso_pkg::FOS_MSB:cso_pkg::FOS_LSB];

  // Straight field outputs, taken from the register flops
  assign o_history_delay  =
    regs_q[cso_pkg::IDX_POLICY][cso_pkg::HIST_MSB:cso_pkg::HIST_LSB];
  assign o_cmos_drive     =
    regs_q[cso_pkg::IDX_DRIVE][cso_pkg::DRIVE_MSB:cso_pkg::DRIVE_LSB];
  assign o_power_down     = sleep;
  assign o_out_one_format = fmt[0];
  assign o_out_two_format = fmt[1];

  // ----------------------------------------------------------------
  // Clock select pin synchroniser
  // ----------------------------------------------------------------
  logic sel_sync1_q;
  logic sel_sync2_q;
  logic sel_sync3_q;
  logic sel_pin_q;

  // A change is accepted only once the second and third stages agree
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sel_sync1_q <= 1'b0;
      sel_sync2_q <= 1'b0;
      sel_sync3_q <= 1'b0;
      sel_pin_q   <= 1'b0;
    end else begin
      sel_sync1_q <= i_clock_select_pin;
      sel_sync2_q <= sel_sync1_q;
      sel_sync3_q <= sel_sync2_q;
      if (sel_sync2_q == sel_sync3_q) begin
        sel_pin_q <= sel_sync3_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input selection state machine
  // ----------------------------------------------------------------
  cso_pkg::cso_sel_state_type sel_q;
  cso_pkg::cso_sel_state_type sel_d;
  cso_pkg::cso_sel_state_type best_sel;
  logic [1:0]                 manual_choice;
  logic                       pref_two;
  logic                       pref_ok;
  logic                       alt_ok;
  logic                       cur_ok;

  // With the pin flag set the register choice is of no consequence
  assign manual_choice = i_select_source_pin_flag
                       ? (sel_pin_q ? cso_pkg::CHOICE_TWO : cso_pkg::CHOICE_ONE)
                       : i_register_input_choice;

  // Reserved priority codes fall back to input one as first choice
  assign pref_two = (i_first_priority_input == cso_pkg::PRIO_TWO);
  assign pref_ok  = pref_two ? i_input_two_ok : i_input_one_ok;
  assign alt_ok   = pref_two ? i_input_one_ok : i_input_two_ok;
  assign cur_ok   = (sel_q == cso_pkg::SEL_ONE && i_input_one_ok)
                 || (sel_q == cso_pkg::SEL_TWO && i_input_two_ok);

  always_comb begin
    if (pref_ok) begin
      best_sel = pref_two ? cso_pkg::SEL_TWO : cso_pkg::SEL_ONE;
    end else if (alt_ok) begin
      best_sel = pref_two ? cso_pkg::SEL_ONE : cso_pkg::SEL_TWO;
    end else begin
      best_sel = cso_pkg::SEL_HOLD;
    end
  end

  // Reserved policy and reserved manual choice keep the current input,
  // which avoids a needless switch on a code with no defined meaning
  always_comb begin
    sel_d = sel_q;
    if (i_forced_holdover) begin
      sel_d = cso_pkg::SEL_HOLD;
    end else begin
      case (policy)
        cso_pkg::POLICY_MANUAL: begin
          if (manual_choice == cso_pkg::CHOICE_ONE) begin
            sel_d = cso_pkg::SEL_ONE;
          end else if (manual_choice == cso_pkg::CHOICE_TWO) begin
            sel_d = cso_pkg::SEL_TWO;
          end
        end
        cso_pkg::POLICY_NONREV: sel_d = cur_ok ? sel_q : best_sel;
        cso_pkg::POLICY_REVERT: sel_d = best_sel;
        default:                sel_d = sel_q;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sel_q <= cso_pkg::SEL_ONE;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign o_active_input_two = (sel_q == cso_pkg::SEL_TWO);
  assign o_holdover_active  = (sel_q == cso_pkg::SEL_HOLD);

  // ----------------------------------------------------------------
  // Offset alarm reference decode
  // ----------------------------------------------------------------
  // Reserved codes select no reference at all
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_offset_ref_select <= cso_pkg::FOS_SEL_NONE;
    end else begin
      case (fos_ref)
        cso_pkg::FOS_XTAL:   o_offset_ref_select <= cso_pkg::FOS_SEL_XTAL;
        cso_pkg::FOS_IN_ONE: o_offset_ref_select <= cso_pkg::FOS_SEL_ONE;
        cso_pkg::FOS_IN_TWO: o_offset_ref_select <= cso_pkg::FOS_SEL_TWO;
        default:             o_offset_ref_select <= cso_pkg::FOS_SEL_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output buffers and glitch-free gates
  // ----------------------------------------------------------------
  cso_gate_if gate_if [2] ();
  logic       buf_en  [2];
  logic       gate_out[2];

  for (genvar g = 0; g < 2; g++) begin : g_out
    // Sleep wins over any format; disable and reserved codes stop the buffer
    assign buf_en[g] = !sleep
                    && fmt[g] != cso_pkg::FMT_DISABLE
                    && fmt[g] != cso_pkg::FMT_RSVD_A
                    && fmt[g] != cso_pkg::FMT_RSVD_B;

    // A stopped buffer parks low through the same gate, so it too stops cleanly
    always_comb begin
      if (!buf_en[g]) begin
        gate_if[g].target = cso_pkg::G_LOW;
      end else if (hold[g] == cso_pkg::HOLD_LOW) begin
        gate_if[g].target = cso_pkg::G_LOW;
      end else if (hold[g] == cso_pkg::HOLD_HIGH) begin
        gate_if[g].target = cso_pkg::G_HIGH;
      end else begin
        gate_if[g].target = cso_pkg::G_PASS;
      end
    end

    assign gate_if[g].raw = i_out_raw_clk[g];
    assign gate_out[g]    = gate_if[g].out;

    cso_out_gate i_cso_out_gate (
      .i_ref_clk (i_ref_clk),
      .i_srst    (i_srst),
      .bus       (gate_if[g].gate)
    );

    // Registered buffer controls; CMOS mode only while the buffer runs
    always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
        o_out_buffer_enable[g] <= 1'b0;
        o_out_cmos_mode[g]     <= 1'b0;
      end else begin
        o_out_buffer_enable[g] <= buf_en[g];
        o_out_cmos_mode[g]     <= buf_en[g] && fmt[g] == cso_pkg::FMT_CMOS;
      end
    end
  end

  assign o_clock_output_one = gate_out[0];
  assign o_clock_output_two = gate_out[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_sleep_off;
    @(posedge i_ref_clk) disable iff (i_srst)
    sleep |=> (o_out_buffer_enable == 2'h0);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("output enabled during sleep");

  property p_fmt_disable;
    @(posedge i_ref_clk) disable iff (i_srst)
    (fmt[1] == cso_pkg::FMT_DISABLE) |=> !o_out_buffer_enable[1];
  endproperty
  a_fmt_disable: assert property (p_fmt_disable) else $error("disabled output running");

  property p_forced_hold;
    @(posedge i_ref_clk) disable iff (i_srst)
    i_forced_holdover |=> o_holdover_active && !o_active_input_two;
  endproperty
  a_forced_hold: assert property (p_forced_hold) else $error("forced holdover not taken");

  property p_manual_reg;
    @(posedge i_ref_clk) disable iff (i_srst)
    (policy == cso_pkg::POLICY_MANUAL && !i_select_source_pin_flag && !i_forced_holdover
      && i_register_input_choice == cso_pkg::CHOICE_TWO) |=> o_active_input_two;
  endproperty
  a_manual_reg: assert property (p_manual_reg) else $error("register choice not applied");

  property p_pin_rules;
    @(posedge i_ref_clk) disable iff (i_srst)
    (policy == cso_pkg::POLICY_MANUAL && i_select_source_pin_flag && !i_forced_holdover)
      |=> (o_active_input_two == $past(sel_pin_q));
  endproperty
  a_pin_rules: assert property (p_pin_rules) else $error("pin choice not applied");

  property p_revert;
    @(posedge i_ref_clk) disable iff (i_srst)
    (policy == cso_pkg::POLICY_REVERT && !i_forced_holdover && pref_two && i_input_two_ok)
      |=> o_active_input_two;
  endproperty
  a_revert: assert property (p_revert) else $error("revertive choice ignores priority");

  property p_nonrev_stay;
    @(posedge i_ref_clk) disable iff (i_srst)
    (policy == cso_pkg::POLICY_NONREV && !i_forced_holdover && o_active_input_two
      && i_input_two_ok) |=> o_active_input_two;
  endproperty
  a_nonrev_stay: assert property (p_nonrev_stay) else $error("non-revertive switched away");

  property p_rsvd_read;
    @(posedge i_ref_clk) disable iff (i_srst)
    (i_reg_rd && reg_hit) |=> ((o_reg_rdata & ~cso_pkg::WR_MASK[$past(reg_idx)])
      == (cso_pkg::RST_VAL[$past(reg_idx)] & ~cso_pkg::WR_MASK[$past(reg_idx)]));
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits changed");

  property p_fos_two;
    @(posedge i_ref_clk) disable iff (i_srst)
    (fos_ref == cso_pkg::FOS_IN_TWO) |=> (o_offset_ref_select == cso_pkg::FOS_SEL_TWO);
  endproperty
  a_fos_two: assert property (p_fos_two) else $error("offset reference decode wrong");
endmodule
`default_nettype wire

// ===== cso_host_model.sv
`default_nettype none
// ----------------------------------------------------------------
// Host side: register strobes changed at falling edges only
// ----------------------------------------------------------------
module cso_host_model (
  input  wire logic       i_ref_clk,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus before the first request
  initial begin
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_addr  = 8'h00;
    o_reg_wdata = 8'h00;
  end

  // One-cycle write; callers pass only legal field codes
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_reg_wr    = 1'b1;
    o_reg_addr  = a;
    o_reg_wdata = d;
    @(negedge i_ref_clk);
    o_reg_wr    = 1'b0;
    o_reg_addr  = ~a;  // Released lines show a changed pattern, not stale data
    o_reg_wdata = ~d;
  endtask

  // One-cycle read strobe; data is collected by the bench monitor
  task automatic rd_reg(input logic [7:0] a);
    @(negedge i_ref_clk);
    o_reg_rd   = 1'b1;
    o_reg_addr = a;
    @(negedge i_ref_clk);
    o_reg_rd   = 1'b0;
    o_reg_addr = ~a;
  endtask
endmodule
`default_nettype wire

// ===== clock_select_output_config_regs_bench.sv
`default_nettype none
module clock_select_output_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, wr, rd, pin = 1'b0, flag = 1'b0, hold = 1'b0;
  logic [7:0] addr, wdata, rdata, exp_v, wv [5];
  logic [1:0] choice = 2'h0, prio = 2'h0, raw = 2'h0, en, cm, drv;
  logic [2:0] f1, f2, frequency_offset_alarm;
  logic [4:0] hist;
  logic rv, act2, hov, pd, o1, o2, s1, s2, ok1 = 1'b1, ok2 = 1'b1;
  logic [7:0] q [$];
  int n_fail = 0, samples_checked = 0;

  always #20 clk = ~clk;
  always @(negedge clk) raw <= ~raw;  // Raw phases toggle every cycle

  cso_host_model i_cso_host_model (.i_ref_clk(clk), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_addr(addr), .o_reg_wdata(wdata));
  cso_top i_cso_top (.i_ref_clk(clk), .i_srst(srst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rd_valid(rv),
    .i_clock_select_pin(pin), .i_select_source_pin_flag(flag),
    .i_register_input_choice(choice), .i_first_priority_input(prio),
    .i_forced_holdover(hold), .i_input_one_ok(ok1), .i_input_two_ok(ok2),
    .i_out_raw_clk(raw), .o_active_input_two(act2), .o_holdover_active(hov),
    .o_history_delay(hist), .o_cmos_drive(drv), .o_power_down(pd),
    .o_out_one_format(f1), .o_out_two_format(f2), .o_out_buffer_enable(en),
    .o_out_cmos_mode(cm), .o_offset_ref_select(frequency_offset_alarm), .o_clock_output_one(o1),
    .o_clock_output_two(o2));

  // ----------------------------------------------------------------
  // Checking and verdict
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Monitor pops the oldest noted read on each valid pulse
  always @(negedge clk) begin
    if (rv === 1'b1) begin
      exp_v = (q.size() > 0) ? q.pop_front() : 8'hxx;
      chk(rdata, exp_v);
    end
  end

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    i_cso_host_model.rd_reg(a);
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Hung run is cut off after ten thousand cycles
  initial begin
    #400000;
    n_fail++;
    summarize;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hb50c735e));
    wt(20);
    srst <= 1'b0;
    // Reset pattern, unmapped neighbours read zero
    for (int a = 3; a < 10; a++)
      rd_exp(a[7:0], (a > 3 && a < 9) ? cso_pkg::RST_VAL[a-4] : 8'h00);
    // Legal codes with reserved bits flipped; reserved bits must keep reset pattern
    wv = '{8'h80 | 8'($urandom & 32'h3f), 8'h7f, 8'h9f, 8'hf9, 8'h6f};
    i_cso_host_model.wr_reg(8'h0a, 8'hff);
    for (int i = 0; i < 5; i++) begin
      i_cso_host_model.wr_reg(8'h04 + i[7:0], wv[i]);
      rd_exp(8'h04 + i[7:0], (cso_pkg::RST_VAL[i] & ~cso_pkg::WR_MASK[i]) |
        (wv[i] & cso_pkg::WR_MASK[i]));
    end
    wt(6);
    chk(hist, wv[0][4:0]);
    chk(drv, 2'h1);
    chk(f1, 3'h7);
    chk(f2, 3'h3);
    chk({en, cm}, 4'hc);
    chk(frequency_offset_alarm, 3'h2);
    // Hold two low and one high while raw keeps toggling
    for (int i = 0; i < 8; i++) begin
      wt(1);
      chk({o2, o1}, 2'h1);
    end
    i_cso_host_model.wr_reg(8'h08, 8'h00);
    wt(4);
    s1 = o1;
    s2 = o2;
    wt(1);
    chk({s2 ^ o2, s1 ^ o1}, 2'h3);
    // Swap the forced levels: two held high, one held low
    i_cso_host_model.wr_reg(8'h08, 8'h90);
    wt(4);
    chk({o2, o1}, 2'h2);
    // Remaining offset reference codes; the host never writes reserved ones
    i_cso_host_model.wr_reg(8'h07, 8'h00);
    wt(2);
    chk(frequency_offset_alarm, 3'h1);
    i_cso_host_model.wr_reg(8'h07, 8'h02);
    wt(2);
    chk(frequency_offset_alarm, 3'h4);
    // Sleep overrides formats; both clocks parked low
    i_cso_host_model.wr_reg(8'h06, 8'h5f);
    wt(4);
    chk({pd, en}, 3'h4);
    for (int i = 0; i < 6; i++) begin
      wt(1);
      chk({o2, o1}, 2'h0);
    end
    i_cso_host_model.wr_reg(8'h06, 8'h12);
    wt(3);
    chk({pd, en, cm}, 5'h0f);
    i_cso_host_model.wr_reg(8'h06, 8'h09);
    wt(3);
    chk(en, 2'h0);
    // Manual from register, then from pin
    i_cso_host_model.wr_reg(8'h04, 8'h00);
    choice <= 2'h1;
    wt(3);
    chk(act2, 1'b1);
    flag <= 1'b1;
    wt(8);
    chk(act2, 1'b0);
    pin <= 1'b1;
    wt(8);
    chk(act2, 1'b1);
    hold <= 1'b1;
    wt(2);
    chk(hov, 1'b1);
    hold <= 1'b0;
    // Automatic with second input ranked first, then revertive to first
    i_cso_host_model.wr_reg(8'h04, 8'h40);
    pin <= 1'b0;
    prio <= 2'h1;
    wt(4);
    chk({hov, act2}, 2'h1);
    i_cso_host_model.wr_reg(8'h04, 8'h80);
    prio <= 2'h0;
    wt(4);
    chk({hov, act2}, 2'h0);
    // First-ranked input fails, then non-revertive keeps the fallback
    ok1 <= 1'b0;
    wt(3);
    chk({hov, act2}, 2'h1);
    i_cso_host_model.wr_reg(8'h04, 8'h40);
    ok1 <= 1'b1;
    wt(3);
    chk({hov, act2}, 2'h1);
    ok2 <= 1'b0;
    wt(3);
    chk({hov, act2}, 2'h0);
    wt(2);
    summarize;
  end
endmodule
`default_nettype wire
